// [rtl/lhi_pkg.sv]
// Package: constants and carriers for the LPC host interrupt block
package lhi_pkg;
    // Host interrupt slots (index = serialized frame number), then frame timing, channel 3 address and reset constants
    localparam int FrmIrq1 = 2;
    localparam int FrmSmi = 3;
    localparam int FrmIrq6 = 7;
    localparam int FrmIrq9 = 10;
    localparam int FrmIrq10 = 11;
    localparam int FrmIrq11 = 12;
    localparam int FrmIrq12 = 13;
    localparam int FrmLast = 17;
    localparam int StatesPerFrame = 3;
    localparam int StartStates = 6;
    localparam logic [15:0] Ch3DataClr = 16'h0005;
    localparam logic [15:0] Ch3StatSet = 16'h0004;
    localparam logic [15:0] BidirFlip = 16'h0010;
    localparam logic [15:0] BidirNibble = 16'hFFF0;
    localparam logic ModStopReset = 1'b1;
    localparam logic [7:0] EnReset = 8'h00;
    localparam int HostIrqs = 7;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_START = 3'b001,
        SQ_FRAME = 3'b010,
        SQ_STOP = 3'b011
    } lhi_sq_e;

    // Host-side events crossing into the CPU domain
    typedef struct packed {
        logic rdOdr1;
        logic rdOdr2;
        logic rdOdr3;
        logic rdBidirLast;
    } lhi_hostrd_s;

    // Host address map of channel 3
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] stat;
        logic [15:0] bidir0;
    } lhi_amap_s;
endpackage

// [rtl/lhi_top.sv]
// LPC host interrupt, clock-run and CPU interrupt logic
module lhi_top import lhi_pkg::*; (
    // CPU clock and reset
    input wire logic sysClk,
    input wire logic rst,
    // Link clock and reset
    input wire logic lpcClk,
    input wire logic lpcRst,
    // Module stop control
    input wire logic moduleStopWr,
    input wire logic moduleStopVal,
    output logic moduleStop,
    // Channel 3 base address
    input wire logic [15:0] hostBaseAddressCh3,
    output lhi_amap_s ch3Map,
    // CPU events and enables
    input wire logic [2:0] cpuOdrWr,
    input wire logic cpuBidirLastWr,
    input wire logic enWr,
    input wire logic [9:0] enWrData,
    output logic [9:0] enRd,
    input wire logic enableDirectMode,
    input wire logic bidirRegsEnable,
    input wire logic [2:0] rxFullIrqEnable,
    input wire logic errorIrqEnable,
    input wire logic lpcResetFlag,
    input wire logic shutdownFlag,
    input wire logic abortFlag,
    // CPU interrupts
    output logic [2:0] rxFullIrq,
    output logic errorIrq,
    // Host events in link domain
    input wire logic [2:0] hostIdrWrDone,
    input wire logic hostBidirLastWrDone,
    input wire lhi_hostrd_s hostRd,
    // Serialized interrupt pin and clock-run pin
    input wire logic serirqIn,
    output logic serirqOut,
    output logic serirqOe,
    input wire logic quietMode,
    input wire logic clkrunIn,
    output logic clkrunOut,
    output logic clkrunOe
);
    // Enable bits: 0 kbd,1 aux,2 smi2,3 smi3data,4 smi3bidir,
    // 5..8 irq6/9/10/11 ch2 packed as irq6 ch2, irq6 ch3 simplified grouping
    // bits 5:ch2 irq6,6:ch3 irq6,7:ch2 irq9-11,8:ch3 irq9-11,9 spare
    logic [9:0] en_q, en_d;
    logic modStop_q, modStop_d;
    logic [2:0] rxIrq_q, rxIrq_d;
    logic errIrq_q, errIrq_d;
    logic [3:0] evTog_q, evTog_d;
    logic [3:0] evS1_q, evS2_q, evS3_q;
    logic [3:0] rdTog_q, rdTog_d;
    logic [3:0] rdS1_q, rdS2_q, rdS3_q;
    logic [3:0] hostEv, rdEv;
    logic [HostIrqs-1:0] req;
    logic [HostIrqs-1:0] reqS1_q, reqS2_q;
    logic [HostIrqs-1:0] pend_q, pend_d;
    lhi_sq_e st_q, st_d;
    logic [4:0] frm_q, frm_d;
    logic [2:0] sub_q, sub_d;
    logic serS1_q, serS2_q, serPrev_q;
    logic ckS1_q, ckS2_q;
    logic clkrun_q, clkrun_d;
    logic qS1_q, qS2_q;
    logic stS1_q, stS2_q;

    function automatic int slotOf(input int i);
        case (i)
            0: slotOf = FrmIrq1;
            1: slotOf = FrmSmi;
            2: slotOf = FrmIrq6;
            3: slotOf = FrmIrq9;
            4: slotOf = FrmIrq10;
            5: slotOf = FrmIrq11;
            default: slotOf = FrmIrq12;
        endcase
    endfunction

    // Channel 3 address decode
    always_comb begin
        ch3Map.data = hostBaseAddressCh3 & ~Ch3DataClr;
        ch3Map.stat = (hostBaseAddressCh3 & ~Ch3DataClr) | Ch3StatSet;
        ch3Map.bidir0 = (hostBaseAddressCh3 ^ BidirFlip) & BidirNibble;
    end

    // Link-domain events toggled for crossing
    always_comb begin
        evTog_d = evTog_q ^ {hostBidirLastWrDone, hostIdrWrDone};
        rdTog_d = rdTog_q ^ {hostRd.rdBidirLast, hostRd.rdOdr3,
                             hostRd.rdOdr2, hostRd.rdOdr1};
    end
    always_ff @(posedge lpcClk) begin
        if (lpcRst) begin
            evTog_q <= 4'h0;
            rdTog_q <= 4'h0;
        end else begin
            evTog_q <= evTog_d;
            rdTog_q <= rdTog_d;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            evS1_q <= 4'h0;
            evS2_q <= 4'h0;
            evS3_q <= 4'h0;
            rdS1_q <= 4'h0;
            rdS2_q <= 4'h0;
            rdS3_q <= 4'h0;
        end else begin
            evS1_q <= evTog_q;
            evS2_q <= evS1_q;
            evS3_q <= evS2_q;
            rdS1_q <= rdTog_q;
            rdS2_q <= rdS1_q;
            rdS3_q <= rdS2_q;
        end
    end
    assign hostEv = evS2_q ^ evS3_q;
    assign rdEv = rdS2_q ^ rdS3_q;

    // CPU-domain enables, module stop and CPU interrupts
    always_comb begin
        logic [9:0] linkClr;
        linkClr = 10'h000;
        modStop_d = moduleStopWr ? moduleStopVal : modStop_q;
        en_d = en_q;
        if (enWr && !modStop_q) begin
            en_d = enWrData;
        end
        linkClr[0] = rdEv[0];
        linkClr[1] = rdEv[0];
        if (!enableDirectMode) begin
            linkClr[2] = rdEv[1];
            linkClr[3] = rdEv[2];
            linkClr[4] = rdEv[3];
            linkClr[5] = rdEv[1];
            linkClr[6] = rdEv[2];
            linkClr[7] = rdEv[1];
            linkClr[8] = rdEv[2];
        end
        en_d = en_d & ~linkClr;
        rxIrq_d = rxIrq_q;
        errIrq_d = 1'b0;
        if (!modStop_q) begin
            rxIrq_d[0] = rxFullIrqEnable[0] && hostEv[0];
            rxIrq_d[1] = rxFullIrqEnable[1] && hostEv[1];
            rxIrq_d[2] = rxFullIrqEnable[2] && (hostEv[2] ||
                (bidirRegsEnable && hostEv[3]));
            errIrq_d = errorIrqEnable && (lpcResetFlag || shutdownFlag ||
                abortFlag);
        end else begin
            rxIrq_d = 3'b000;
        end
    end
    always_ff @(posedge sysClk) begin
        if (rst) begin
            en_q <= {2'b00, EnReset};
            modStop_q <= ModStopReset;
            rxIrq_q <= 3'b000;
            errIrq_q <= 1'b0;
        end else begin
            en_q <= en_d;
            modStop_q <= modStop_d;
            rxIrq_q <= rxIrq_d;
            errIrq_q <= errIrq_d;
        end
    end
    assign enRd = en_q;
    assign moduleStop = modStop_q;
    assign rxFullIrq = rxIrq_q;
    assign errorIrq = errIrq_q;

    // Host request levels per slot
    always_comb begin
        req = '0;
        req[0] = en_q[0];
        req[1] = en_q[2] | en_q[3] | en_q[4];
        req[2] = en_q[5] | en_q[6];
        req[3] = en_q[7] | en_q[8];
        req[4] = en_q[7] | en_q[8];
        req[5] = en_q[7] | en_q[8];
        req[6] = en_q[1];
        if (modStop_q) begin
            req = '0;
        end
    end
    // cpuOdrWr/cpuBidirLastWr are unused: they only feed unusedWr and gate no enable
    logic unusedWr;
    assign unusedWr = |{cpuOdrWr, cpuBidirLastWr};

    // Link-domain serializer; clock-run follows on sysClk
    always_comb begin
        st_d = st_q;
        frm_d = frm_q;
        sub_d = sub_q;
        pend_d = pend_q | reqS2_q;
        serirqOut = 1'b1;
        serirqOe = 1'b1;
        case (st_q)
            SQ_IDLE: begin
                if (serPrev_q && !serS2_q) begin
                    st_d = SQ_START;
                    sub_d = 3'd1;
                end else if (qS2_q && |pend_q && !stS2_q) begin
                    serirqOut = 1'b0;
                    serirqOe = 1'b0;
                    st_d = SQ_START;
                    sub_d = 3'd1;
                end
            end
            SQ_START: begin
                sub_d = sub_q + 3'd1;
                if (sub_q == 3'(StartStates - 1)) begin
                    st_d = SQ_FRAME;
                    frm_d = 5'd1;
                    sub_d = 3'd0;
                end
            end
            SQ_FRAME: begin
                for (int i = 0; i < HostIrqs; i++) begin
                    if (frm_q == 5'(slotOf(i)) && pend_q[i]) begin
                        if (sub_q == 3'd0) begin
                            serirqOut = 1'b0;
                            serirqOe = 1'b0;
                        end else if (sub_q == 3'd1) begin
                            serirqOe = 1'b0;
                            pend_d[i] = reqS2_q[i];
                        end
                    end
                end
                sub_d = sub_q + 3'd1;
                if (sub_q == 3'(StatesPerFrame - 1)) begin
                    sub_d = 3'd0;
                    frm_d = frm_q + 5'd1;
                    if (frm_q == 5'(FrmLast)) begin
                        st_d = SQ_STOP;
                    end
                end
            end
            SQ_STOP: begin
                if (serS2_q && !serPrev_q) begin
                    st_d = SQ_IDLE;
                end
            end
            default: st_d = SQ_IDLE;
        endcase
        pend_d = pend_d & reqS2_q;
    end
    always_ff @(posedge lpcClk) begin
        if (lpcRst) begin
            st_q <= SQ_IDLE;
            frm_q <= 5'd0;
            sub_q <= 3'd0;
            pend_q <= '0;
            reqS1_q <= '0;
            reqS2_q <= '0;
            serS1_q <= 1'b1;
            serS2_q <= 1'b1;
            serPrev_q <= 1'b1;
            qS1_q <= 1'b0;
            qS2_q <= 1'b0;
            stS1_q <= 1'b1;
            stS2_q <= 1'b1;
        end else begin
            st_q <= st_d;
            frm_q <= frm_d;
            sub_q <= sub_d;
            pend_q <= pend_d;
            reqS1_q <= req;
            reqS2_q <= reqS1_q;
            serS1_q <= serirqIn;
            serS2_q <= serS1_q;
            serPrev_q <= serS2_q;
            qS1_q <= quietMode;
            qS2_q <= qS1_q;
            stS1_q <= modStop_q;
            stS2_q <= stS1_q;
        end
    end

    // Clock-run runs on sysClk since lpcClk may be stopped
    logic qC1_q, qC2_q, pC1_q, pC2_q;
    always_comb begin
        clkrun_d = qC2_q && pC2_q && ckS2_q && !modStop_q;
    end
    always_ff @(posedge sysClk) begin
        if (rst) begin
            ckS1_q <= 1'b0;
            ckS2_q <= 1'b0;
            qC1_q <= 1'b0;
            qC2_q <= 1'b0;
            pC1_q <= 1'b0;
            pC2_q <= 1'b0;
            clkrun_q <= 1'b0;
        end else begin
            ckS1_q <= clkrunIn;
            ckS2_q <= ckS1_q;
            qC1_q <= quietMode;
            qC2_q <= qC1_q;
            pC1_q <= |req;
            pC2_q <= pC1_q;
            clkrun_q <= clkrun_d;
        end
    end
    assign clkrunOut = 1'b0;
    assign clkrunOe = !clkrun_q;
endmodule // lhi_top

// [verification/lhi_host_model.sv]
// Host controller model: resolves the serialized irq and clock-run wires
module lhi_host_model (
    // Device pin halves
    input wire logic serirqOut,
    input wire logic serirqOe,
    input wire logic clkrunOut,
    input wire logic clkrunOe,
    // Host state
    input wire logic clkStopped,
    // Resolved wire levels
    output logic serirqIn,
    output logic clkrunIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up while the device leaves the line
    assign serirqIn = serirqOe ? 1'b1 : serirqOut;
    // Host holds clock-run low while its clock runs
    assign clkrunIn = !clkrunOe ? clkrunOut : clkStopped;
endmodule // lhi_host_model

// [verification/lhi_checker.sv]
// Assertion checker for the LPC host interrupt block
module lhi_checker import lhi_pkg::*; (
    // Clocks and resets
    input wire logic sysClk,
    input wire logic rst,
    input wire logic lpcClk,
    input wire logic lpcRst,
    // CPU side
    input wire logic moduleStop,
    input wire logic enWr,
    input wire logic [9:0] enRd,
    input wire logic [15:0] hostBaseAddressCh3,
    input wire lhi_amap_s ch3Map,
    input wire logic [2:0] rxFullIrqEnable,
    input wire logic errorIrqEnable,
    input wire logic lpcResetFlag,
    input wire logic shutdownFlag,
    input wire logic abortFlag,
    input wire logic [2:0] rxFullIrq,
    input wire logic errorIrq,
    // Link side
    input wire logic quietMode,
    input wire logic clkrunOut,
    input wire logic clkrunOe
);
    a_clkrun_low: assert property (@(posedge lpcClk) disable iff (lpcRst)
        !clkrunOe |-> !clkrunOut) else $error("clock-run driven high");
    a_clkrun_cont: assert property (@(posedge lpcClk) disable iff (lpcRst)
        !quietMode && !$past(quietMode, 3) |-> clkrunOe)
        else $error("clock-run request in continuous mode");
    a_clkrun_release: assert property (@(posedge lpcClk) disable iff (lpcRst)
        !clkrunOe |-> ##[1:8] clkrunOe) else $error("clock-run held");
    a_err_set: assert property (@(posedge sysClk) disable iff (rst)
        errorIrqEnable && (lpcResetFlag || shutdownFlag || abortFlag)
        |=> errorIrq) else $error("error irq missing");
    a_err_clear: assert property (@(posedge sysClk) disable iff (rst)
        !(errorIrqEnable && (lpcResetFlag || shutdownFlag || abortFlag))
        |=> !errorIrq) else $error("error irq without cause");
    a_rx_cause: assert property (@(posedge sysClk) disable iff (rst)
        |rxFullIrq |-> (rxFullIrq & ~$past(rxFullIrqEnable)) == 3'h0)
        else $error("receive irq while disabled");
    a_rx_pulse: assert property (@(posedge sysClk) disable iff (rst)
        |rxFullIrq |=> rxFullIrq == 3'h0) else $error("receive irq stuck");
    a_stop_reset: assert property (@(posedge sysClk) disable iff (rst)
        $past(rst) |-> moduleStop) else $error("module stop not set");
    a_stop_refuse: assert property (@(posedge sysClk) disable iff (rst)
        moduleStop && enWr |=> $stable(enRd)) else $error("write in stop");
    a_map_data: assert property (@(posedge sysClk) disable iff (rst)
        ch3Map.data == (hostBaseAddressCh3 & ~Ch3DataClr) &&
        ch3Map.stat == ((hostBaseAddressCh3 & ~Ch3DataClr) | Ch3StatSet))
        else $error("channel 3 data or status address");
    a_map_bidir: assert property (@(posedge sysClk) disable iff (rst)
        ch3Map.bidir0 == ((hostBaseAddressCh3 ^ BidirFlip) & BidirNibble))
        else $error("bidir base address");
endmodule // lhi_checker

bind lhi_top lhi_checker i_lhi_checker (.sysClk, .rst, .lpcClk, .lpcRst,
    .moduleStop, .enWr, .enRd, .hostBaseAddressCh3, .ch3Map,
    .rxFullIrqEnable, .errorIrqEnable, .lpcResetFlag, .shutdownFlag,
    .abortFlag, .rxFullIrq, .errorIrq, .quietMode, .clkrunOut, .clkrunOe);

// [verification/tb_lhi_top.sv]
// Testbench for the LPC host interrupt block
module tb_lhi_top import lhi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sysClk = 0, rst = 1, lpcClk = 0, lpcRst = 1, clkStopped = 0;
    logic moduleStopWr = 0, moduleStopVal = 0, moduleStop, enWr = 0;
    logic [15:0] hostBaseAddressCh3 = 16'h0000;
    lhi_amap_s ch3Map;
    logic [2:0] cpuOdrWr = 0, rxFullIrqEnable = 0, rxFullIrq, rxSeen = 0;
    logic [2:0] hostIdrWrDone = 0;
    logic [9:0] enWrData = 0, enRd;
    logic cpuBidirLastWr = 0, enableDirectMode = 0, bidirRegsEnable = 0;
    logic errorIrqEnable = 0, lpcResetFlag = 0, shutdownFlag = 0;
    logic abortFlag = 0, errorIrq, hostBidirLastWrDone = 0, serirqIn;
    logic serirqOut, serirqOe, quietMode = 0, clkrunIn, clkrunOut, clkrunOe;
    int clkLow = 0, serLow = 0, lastLow = 0, serGap = 0, lpcCyc = 0;
    lhi_hostrd_s hostRd = '0;
    int errors = 0, comparisons = 0;
    always #25 sysClk = ~sysClk;
    always #24 lpcClk = ~lpcClk;
    always @(posedge sysClk) rxSeen <= rxSeen | rxFullIrq;
    always @(posedge lpcClk) if (!clkrunOe) clkLow <= clkLow + 1;
    // Serialized irq drive, sampled mid-cycle where it is settled
    always @(negedge lpcClk) begin
        lpcCyc <= lpcCyc + 1;
        if (!serirqOe && !serirqOut) begin
            serLow <= serLow + 1;
            lastLow <= lpcCyc;
            serGap <= lpcCyc - lastLow;
        end
    end
    lhi_top i_lhi_top (.sysClk, .rst, .lpcClk, .lpcRst, .moduleStopWr,
        .moduleStopVal, .moduleStop, .hostBaseAddressCh3, .ch3Map,
        .cpuOdrWr, .cpuBidirLastWr, .enWr, .enWrData, .enRd,
        .enableDirectMode, .bidirRegsEnable, .rxFullIrqEnable,
        .errorIrqEnable, .lpcResetFlag, .shutdownFlag, .abortFlag,
        .rxFullIrq, .errorIrq, .hostIdrWrDone, .hostBidirLastWrDone,
        .hostRd, .serirqIn, .serirqOut, .serirqOe, .quietMode, .clkrunIn,
        .clkrunOut, .clkrunOe);
    lhi_host_model i_lhi_host_model (.serirqOut, .serirqOe, .clkrunOut,
        .clkrunOe, .clkStopped, .serirqIn, .clkrunIn);
    task automatic chk(input string nm, input logic [15:0] exp, got);
        comparisons++;
        if (exp !== got) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sysClk);
    endtask
    task automatic setEn(input logic [9:0] v);
        enWr = 1;
        enWrData = v;
        cyc(1);
        enWr = 0;
        cyc(1);
    endtask
    task automatic link(input logic [2:0] idr, input logic last,
        input lhi_hostrd_s rd);
        @(negedge lpcClk);
        {hostIdrWrDone, hostBidirLastWrDone, hostRd} = {idr, last, rd};
        @(negedge lpcClk);
        {hostIdrWrDone, hostBidirLastWrDone, hostRd} = '0;
        repeat (2) @(negedge lpcClk);
        cyc(6);
    endtask
    task automatic conclude();
        $display("Comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_reset();
        chk("moduleStop", 1, moduleStop);
        chk("enRd", 0, enRd);
        chk("irqs", 0, {errorIrq, rxFullIrq});
        chk("oe", 2'b11, {serirqOe, clkrunOe});
    endtask
    task automatic t_map();
        logic [15:0] b[2] = '{16'hA24F, 16'h3FD0};
        logic [15:0] d[2] = '{16'hA24A, 16'h3FD0};
        logic [15:0] s[2] = '{16'hA24E, 16'h3FD4};
        logic [15:0] w[2] = '{16'hA250, 16'h3FC0};
        for (int i = 0; i < 2; i++) begin
            hostBaseAddressCh3 = b[i];
            cyc(1);
            chk("data", d[i], ch3Map.data);
            chk("stat", s[i], ch3Map.stat);
            chk("bidir0", w[i], ch3Map.bidir0);
        end
    endtask
    task automatic t_stop();
        setEn(10'h3FF);
        chk("enRd stopped", 0, enRd);
        moduleStopWr = 1;
        cyc(1);
        moduleStopWr = 0;
        cyc(1);
        chk("moduleStop", 0, moduleStop);
    endtask
    task automatic t_rx();
        rxFullIrqEnable = 3'b111;
        bidirRegsEnable = 1;
        for (int k = 0; k < 3; k++) begin
            rxSeen = 0;
            link(3'b001 << k, 0, '0);
            chk("rxFullIrq", 3'b001 << k, rxSeen);
        end
        rxSeen = 0;
        link(0, 1, '0);
        chk("rx bidir", 3'b100, rxSeen);
        bidirRegsEnable = 0;
        rxSeen = 0;
        link(0, 1, '0);
        chk("rx bidir off", 0, rxSeen);
        rxFullIrqEnable = 0;
        link(3'b111, 0, '0);
        chk("rx disabled", 0, rxSeen);
    endtask
    task automatic t_err();
        errorIrqEnable = 1;
        for (int i = 0; i < 3; i++) begin
            {lpcResetFlag, shutdownFlag, abortFlag} = 3'b100 >> i;
            cyc(2);
            chk("errorIrq", 1, errorIrq);
        end
        errorIrqEnable = 0;
        cyc(2);
        chk("errorIrq off", 0, errorIrq);
        {lpcResetFlag, shutdownFlag, abortFlag} = 0;
    endtask
    task automatic t_host();
        cpuOdrWr = 3'b001;
        cyc(1);
        cpuOdrWr = 0;
        setEn(10'h003);
        chk("kbd set", 10'h003, enRd);
        link(0, 0, 4'b1000);
        chk("kbd read", 0, enRd);
        setEn(10'h1FC);
        link(0, 0, 4'b0100);
        chk("linked ch2", 10'h158, enRd);
        link(0, 0, 4'b0010);
        chk("linked ch3", 10'h010, enRd);
        link(0, 0, 4'b0001);
        chk("linked last", 0, enRd);
        enableDirectMode = 1;
        setEn(10'h1FC);
        link(0, 0, 4'b0111);
        chk("direct kept", 10'h1FC, enRd);
        setEn(0);
        chk("direct clear", 0, enRd);
        enableDirectMode = 0;
    endtask
    task automatic t_clkrun();
        logic [15:0] n;
        clkStopped = 1;
        setEn(10'h001);
        repeat (40) @(negedge lpcClk);
        chk("clkrun cont", 0, 16'(clkLow));
        chk("serirq cont", 0, 16'(serLow));
        setEn(0);
        quietMode = 1;
        setEn(10'h001);
        repeat (40) @(negedge lpcClk);
        chk("clkrun quiet", 1, clkLow > 0);
        chk("clkrunOut", 0, clkrunOut);
        chk("serirq drives", 2, 16'(serLow));
        n = 16'(StartStates + (FrmIrq1 - 1) * StatesPerFrame);
        chk("serirq frame", n, 16'(serGap));
        // Host restarts its clock and holds clock-run low
        clkStopped = 0;
        repeat (10) @(negedge lpcClk);
        n = 16'(clkLow);
        repeat (40) @(negedge lpcClk);
        chk("clkrun release", n, 16'(clkLow));
        setEn(0);
        quietMode = 0;
    endtask
    initial begin
        cyc(6);
        rst = 0;
        @(negedge lpcClk);
        lpcRst = 0;
        cyc(2);
        t_reset();
        t_map();
        t_stop();
        t_rx();
        t_err();
        t_host();
        t_clkrun();
        conclude();
    end
    initial begin
        #100000;
        errors++;
        $display("Error watchdog expected done seen timeout");
        conclude();
    end
endmodule // tb_lhi_top
